// ---- i2c_flags_pkg.sv ----
// constants for the slave status flag block
package i2c_flags_pkg;
   localparam logic [3:0] addr_status  = 4'h0;
   localparam logic [3:0] addr_control = 4'h1;
   localparam logic [3:0] addr_slot0   = 4'h2;
   localparam logic [3:0] addr_alt     = 4'h6;
   localparam logic [3:0] addr_irq_st  = 4'h7;
   localparam logic [3:0] addr_irq_clr = 4'h8;
   localparam logic [3:0] addr_irq_en  = 4'h9;
   localparam logic [3:0] addr_rx_pop  = 4'hA;
   // control register bits
   localparam int ctl_gc_enable  = 0;
   localparam int ctl_hw_gc      = 1;
   localparam int ctl_force_nack = 2;
   localparam int ctl_stop_ie    = 3;
   localparam int ctl_rx_ie      = 4;
   localparam int ctl_gc_clear   = 5;
   // status bit positions
   localparam int st_start  = 14;
   localparam int st_reps   = 13;
   localparam int st_id_lo  = 11;
   localparam int st_stop   = 10;
   localparam int st_gc_lo  = 8;
   localparam int st_gc     = 7;
   localparam int st_busy   = 6;
   localparam int st_nack   = 5;
   localparam int st_ovf    = 4;
   localparam int st_rxq    = 3;
   localparam logic [7:0] gc_address  = 8'h00;
   localparam logic [7:0] start_byte  = 8'h01;
   localparam logic [7:0] gc_reset    = 8'h06;
   localparam logic [7:0] gc_program  = 8'h04;
   localparam logic [1:0] kind_none   = 2'h0;
   localparam logic [1:0] kind_reset  = 2'h1;
   localparam logic [1:0] kind_prog   = 2'h2;
   localparam logic [1:0] kind_hw     = 2'h3;
   localparam int rx_depth = 2;
   localparam logic [1:0] rx_full_count = 2'h2;
   // interrupt event bits
   localparam int ev_stop = 0;
   localparam int ev_rx   = 1;
   localparam int ev_gc   = 2;
endpackage

// ---- i2c_flags_props.sv ----
// port assertions for the slave status flag block
`timescale 1ns/1ps
`default_nettype none
module i2c_flags_props
   import i2c_flags_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic [3:0]  address,
   input wire logic [15:0] write_data,
   input wire logic        write_strobe,
   input wire logic        read_strobe,
   input wire logic [15:0] read_data,
   input wire logic        irq
);
   logic [3:0] quiet;
   logic [3:0] oe_len;
   logic       stopped;
   logic       scl_q;
   logic       sda_q;
   wire logic  st_rd = read_strobe && address == addr_status;
   ////////////////////////////////////////////////////////////////////////////////
   // pins lag ~3 clk inside the design, so flags are judged only on a quiet bus
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         quiet <= 4'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         stopped <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         quiet <= (scl_q != scl_in || sda_q != sda_in) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
         if (scl_in && sda_in && !sda_q) stopped <= 1'b1;
         if (scl_in && !sda_in && sda_q) stopped <= 1'b0;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) oe_len <= 4'h0;
      else oe_len <= sda_oe ? oe_len + 4'h1 : 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);
   reset_quiet_a: assert property (disable iff (1'b0) reset |-> read_data == 16'h0000 && !irq)
      else $error("outputs active in reset");
   top_bit_a: assert property (read_strobe |=> !read_data[15])
      else $error("status bit 15 set");
   read_idle_a: assert property (!$past(read_strobe) |-> read_data == 16'h0000)
      else $error("read data outside read cycle");
   read_clears_a: assert property (st_rd && quiet > 4'h5 ##1 st_rd |=>
      !read_data[st_stop] && !read_data[st_reps]) else $error("status read did not clear");
   stop_clears_a: assert property (st_rd && stopped && quiet > 4'h5 |=>
      read_data[14:13] == 2'b00 && !read_data[st_busy]) else $error("flags survive stop");
   gc_clear_a: assert property (write_strobe && address == addr_control &&
      write_data[ctl_gc_clear] && quiet > 4'h5 ##1 st_rd |=> read_data[9:7] == 3'b000)
      else $error("general call clear ignored");
   irq_mask_a: assert property (write_strobe && address == addr_irq_en &&
      write_data[2:0] == 3'b000 |=> !irq) else $error("masked interrupt raised");
   ack_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_in) && !sda_out)
      else $error("ack changed while clock high");
   ack_short_a: assert property (oe_len < 4'hC)
      else $error("ack held too long");
   cover property (st_rd ##1 st_rd);
   cover property ($rose(irq));
   cover property ($rose(sda_oe));
endmodule
bind i2c_slave_status_flags i2c_flags_props i2c_flags_props_inst (.clk(clk), .reset(reset),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .address(address),
   .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
   .read_data(read_data), .irq(irq));
`default_nettype wire

// ---- i2c_master_model.sv ----
// behavioural bus master driving the link pins
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // scl stands high between frames; 200 ns bit period
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic start_cond();
      sda_low = 1'b0;
      #50 scl = 1'b1;
      #50 sda_low = 1'b1;
      #50 scl = 1'b0;
      #50;
   endtask
   task automatic stop_cond();
      sda_low = 1'b1;
      #50 scl = 1'b1;
      #50 sda_low = 1'b0;
      #50;
   endtask
   // data changes a quarter after scl falls, never while scl is high
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = !b[i];
         #50 scl = 1'b1;
         #100 scl = 1'b0;
         #50;
      end
      sda_low = 1'b0;
      #50 scl = 1'b1;
      #50 ack = !sda;
      #50 scl = 1'b0;
      #50;
   endtask
endmodule
`default_nettype wire

// ---- i2c_slave_status_flags.sv ----
// i2c slave with status flags, register port and interrupt
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_status_flags
   import i2c_flags_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [3:0]  address,
   input  wire logic [15:0] write_data,
   input  wire logic        write_strobe,
   input  wire logic        read_strobe,
   output logic      [15:0] read_data,
   input  wire logic        tx_has_data,
   output logic             irq
);
   typedef enum logic [4:0] {
      s_idle = 5'b00001,
      s_addr = 5'b00010,
      s_ack  = 5'b00100,
      s_data = 5'b01000,
      s_skip = 5'b10000
   } phase_e;

   logic [1:0]  scl_sync;
   logic [1:0]  sda_sync;
   logic        scl_q;
   logic        sda_q;
   logic [7:0]  control;
   logic [7:0]  slot [4];
   logic [7:0]  alt_id;
   logic [15:0] status;
   logic [2:0]  irq_status;
   logic [2:0]  irq_enable;
   phase_e      phase;
   logic [3:0]  bit_count;
   logic [7:0]  shift;
   logic        ack_drive;
   logic        is_gc;
   logic        gc_second;
   logic        matched_once;
   logic        in_frame;
   logic [7:0]  rx_mem [rx_depth];
   logic [1:0]  rx_count;
   logic        rx_wptr;
   logic        rx_rptr;
   logic        gc_reset_pulse;

   wire scl_rise = scl_sync[1] & ~scl_q;
   wire scl_fall = ~scl_sync[1] & scl_q;
   wire start_ev = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
   wire stop_ev  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
   wire byte_done = scl_rise & (bit_count == 4'h7);
   wire [7:0] rx_byte = {shift[6:0], sda_sync[1]};
   wire status_read = read_strobe & (address == addr_status);
   wire ctl_write = write_strobe & (address == addr_control);
   wire gc_clear = ctl_write & write_data[ctl_gc_clear];
   wire rx_read = read_strobe & (address == addr_rx_pop);
   // hardware general call keeps its id byte for software to compare
   wire hw_gc_byte = control[ctl_hw_gc] & (rx_byte == alt_id);
   wire rx_push = (phase == s_data) & byte_done
                  & (~is_gc | gc_second | hw_gc_byte);

   function automatic logic [2:0] match_slot(input logic [6:0] a,
                                             input logic [7:0] s0, input logic [7:0] s1,
                                             input logic [7:0] s2, input logic [7:0] s3);
      match_slot = 3'h0;
      if (a == s0[7:1]) match_slot = 3'b100;
      else if (a == s1[7:1]) match_slot = 3'b101;
      else if (a == s2[7:1]) match_slot = 3'b110;
      else if (a == s3[7:1]) match_slot = 3'b111;
   endfunction

   wire [2:0] hit = match_slot(rx_byte[7:1], slot[0], slot[1], slot[2], slot[3]);
   wire gc_hit = control[ctl_gc_enable] & (rx_byte == gc_address);
   wire sb_hit = (rx_byte == start_byte);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, second stage only is used
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_q    <= scl_sync[1];
         sda_q    <= sda_sync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus framing
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase     <= s_idle;
         bit_count <= 4'h0;
         shift     <= 8'h00;
         ack_drive <= 1'b0;
         is_gc     <= 1'b0;
         gc_second <= 1'b0;
      end else if (start_ev) begin
         phase     <= s_addr;
         bit_count <= 4'h0;
         ack_drive <= 1'b0;
         is_gc     <= 1'b0;
         gc_second <= 1'b0;
      end else if (stop_ev) begin
         phase     <= s_idle;
         ack_drive <= 1'b0;
      end else begin
         case (phase)
            s_addr: begin
               if (scl_rise) begin
                  shift     <= rx_byte;
                  bit_count <= bit_count + 4'h1;
               end
               if (byte_done) begin
                  bit_count <= 4'h0;
                  // nack when reading with nothing queued or forced
                  if ((hit[2] | gc_hit) & ~control[ctl_force_nack]
                      & ~(rx_byte[0] & ~tx_has_data)) begin
                     phase     <= s_ack;
                     ack_drive <= 1'b0;
                     // general call wins over a slot left at its zero default
                     is_gc     <= gc_hit;
                  end else begin
                     phase <= s_skip;
                  end
               end
            end
            s_ack: begin
               if (scl_fall & ~ack_drive) ack_drive <= 1'b1;
               else if (scl_fall & ack_drive) begin
                  ack_drive <= 1'b0;
                  phase     <= s_data;
               end
            end
            s_data: begin
               if (scl_rise) begin
                  shift     <= rx_byte;
                  bit_count <= bit_count + 4'h1;
               end
               if (byte_done) begin
                  bit_count <= 4'h0;
                  phase     <= s_ack;
                  if (is_gc) gc_second <= 1'b1;
               end
            end
            s_skip: phase <= s_skip;
            default: phase <= s_idle;
         endcase
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = ack_drive;
   assign in_frame = (phase != s_idle);

   ////////////////////////////////////////////////////////////////////////////
   // registers writable by software
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         control <= 8'h00;
         alt_id  <= 8'h00;
         for (int i = 0; i < 4; i++) slot[i] <= 8'h00;
      end else if (gc_reset_pulse) begin
         control <= 8'h00;
         alt_id  <= 8'h00;
         for (int i = 0; i < 4; i++) slot[i] <= 8'h00;
      end else if (write_strobe) begin
         if (address == addr_control) control <= {2'h0, 1'b0, write_data[4:0]};
         else if (address == addr_alt) alt_id <= write_data[7:0];
         else if (address >= addr_slot0 && address < addr_alt)
            slot[2'(address - addr_slot0)] <= write_data[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive fifo
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_count <= 2'h0;
         rx_wptr  <= 1'b0;
         rx_rptr  <= 1'b0;
         rx_mem[0] <= 8'h00;
         rx_mem[1] <= 8'h00;
      end else begin
         if (rx_push && rx_count != rx_full_count) begin
            rx_mem[rx_wptr] <= rx_byte;
            rx_wptr <= ~rx_wptr;
         end
         if (rx_read && rx_count != 2'h0) rx_rptr <= ~rx_rptr;
         rx_count <= rx_count + 2'((rx_push && rx_count != rx_full_count) ? 1 : 0)
                     - 2'((rx_read && rx_count != 2'h0) ? 1 : 0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags
   assign gc_reset_pulse = (phase == s_data) & byte_done & is_gc & ~gc_second
                           & (rx_byte == gc_reset);
   wire gc_first = (phase == s_data) & byte_done & is_gc & ~gc_second;
   wire addr_ok  = (phase == s_addr) & byte_done & (hit[2] | gc_hit | sb_hit);
   wire addr_bad = (phase == s_addr) & byte_done & ~(hit[2] | gc_hit);
   wire nack_ev  = (phase == s_addr) & byte_done & (hit[2] | gc_hit)
                   & (control[ctl_force_nack] | (rx_byte[0] & ~tx_has_data));
   wire stop_set = stop_ev & matched_once;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status       <= 16'h0000;
         matched_once <= 1'b0;
      end else begin
         if (addr_ok) status[st_start] <= 1'b1;
         else if (stop_ev) status[st_start] <= 1'b0;
         if (start_ev & in_frame) status[st_reps] <= 1'b1;
         else if (stop_ev | status_read) status[st_reps] <= 1'b0;
         if (addr_ok & hit[2]) status[st_id_lo +: 2] <= hit[1:0];
         if (addr_ok & hit[2]) matched_once <= 1'b1;
         else if (stop_ev) matched_once <= 1'b0;
         // set wins over the read clear
         if (stop_set) status[st_stop] <= 1'b1;
         else if (status_read) status[st_stop] <= 1'b0;
         if (gc_first & (rx_byte == gc_reset)) status[st_gc_lo +: 2] <= kind_reset;
         else if (gc_first & (rx_byte == gc_program)) status[st_gc_lo +: 2] <= kind_prog;
         else if (gc_first & hw_gc_byte)
            status[st_gc_lo +: 2] <= kind_hw;
         else if (gc_clear) status[st_gc_lo +: 2] <= kind_none;
         if (gc_first) status[st_gc] <= 1'b1;
         else if (gc_clear) status[st_gc] <= 1'b0;
         if (start_ev) status[st_busy] <= 1'b1;
         else if (addr_bad | stop_ev) status[st_busy] <= 1'b0;
         if (nack_ev) status[st_nack] <= 1'b1;
         else if (addr_ok) status[st_nack] <= 1'b0;
         status[st_ovf] <= (rx_push && rx_count == rx_full_count);
         status[st_rxq] <= (rx_count != 2'h0);
         status[15] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: sticky events, write-one clear, enable mask
   wire [2:0] events = {gc_first, status[st_rxq] & control[ctl_rx_ie],
                        stop_set & control[ctl_stop_ie]};
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_status <= 3'h0;
         irq_enable <= 3'h0;
      end else begin
         irq_status <= events
                       | (irq_status & ~((write_strobe && address == addr_irq_clr)
                                         ? write_data[2:0] : 3'h0));
         if (write_strobe && address == addr_irq_en) irq_enable <= write_data[2:0];
      end
   end
   assign irq = |(irq_status & irq_enable);

   ////////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) read_data <= 16'h0000;
      else if (read_strobe) begin
         if (address == addr_status) read_data <= status;
         else if (address == addr_control) read_data <= {8'h00, control};
         else if (address == addr_alt) read_data <= {8'h00, alt_id};
         else if (address == addr_irq_st) read_data <= {13'h0, irq_status};
         else if (address == addr_irq_en) read_data <= {13'h0, irq_enable};
         else if (address == addr_rx_pop) read_data <= {8'h00, rx_mem[rx_rptr]};
         else if (address >= addr_slot0 && address < addr_alt)
            read_data <= {8'h00, slot[2'(address - addr_slot0)]};
         else read_data <= 16'h0000;
      end else read_data <= 16'h0000;
   end
endmodule
`default_nettype wire

// ---- i2c_slave_status_flags_tb.sv ----
// self-checking bench for the slave status flag block
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_status_flags_tb
   import i2c_flags_pkg::*;
;
   typedef struct packed {
      logic [15:0] ctl;
      logic [7:0]  abyte;
      logic        tx;
      logic        ack;
      logic [15:0] mask;
      logic [15:0] exp;
   } row_s;
   row_s rows [8] = '{
      '{16'h0008, 8'h40, 1'b1, 1'b1, 16'hFFF8, 16'h4040}, '{16'h0008, 8'h42, 1'b1, 1'b1, 16'hFFF8, 16'h4840},
      '{16'h0008, 8'h44, 1'b1, 1'b1, 16'hFFF8, 16'h5040}, '{16'h0008, 8'h46, 1'b1, 1'b1, 16'hFFF8, 16'h5840},
      '{16'h0008, 8'h50, 1'b1, 1'b0, 16'h4040, 16'h0000}, '{16'h000C, 8'h40, 1'b1, 1'b0, 16'h0020, 16'h0020},
      '{16'h0008, 8'h41, 1'b0, 1'b0, 16'h0020, 16'h0020}, '{16'h0008, 8'h41, 1'b1, 1'b1, 16'h4060, 16'h4040}};
   logic        clk = 1'b0;
   logic        reset;
   logic        scl;
   logic        sda_low;
   wire logic   sda_bus;
   logic        sda_out;
   logic        sda_oe;
   logic [3:0]  address;
   logic [15:0] write_data;
   logic        write_strobe;
   logic        read_strobe;
   logic [15:0] read_data;
   logic        tx_has_data;
   logic        irq;
   logic        ack;
   logic [15:0] d;
   logic        ovf_seen;
   int          err_count = 0;
   int          checks_done = 0;
   // pull-up on the shared data line
   assign sda_bus = !(sda_low || (sda_oe && !sda_out));
   always #12.5 clk = ~clk;
   i2c_master_model i2c_master_model_inst (.scl(scl), .sda_low(sda_low), .sda(sda_bus));
   i2c_slave_status_flags i2c_slave_status_flags_inst (.clk(clk), .reset(reset), .scl_in(scl),
      .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .address(address),
      .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
      .read_data(read_data), .tx_has_data(tx_has_data), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      address <= a;
      write_data <= v;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      #1 v = read_data;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
      checks_done++;
      if ((got & mask) !== (exp & mask)) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      err_count++;
      complete_run();
   end
   initial begin
      reset = 1'b1;
      address = 4'h0;
      write_data = 16'h0000;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      tx_has_data = 1'b1;
      wt(10);
      reset <= 1'b0;
      rd(addr_status, d);
      cmp(d, 16'h0000, 16'hFFFF);
      rd(4'hF, d);
      cmp(d, 16'h0000, 16'hFFFF);
      $display("reset test done");
      for (int k = 0; k < 4; k++) wr(4'(k + 2), 16'h0040 + 16'(2 * k));
      wr(addr_irq_en, 16'h0001);
      for (int i = 0; i < 8; i++) begin
         wr(addr_control, rows[i].ctl);
         tx_has_data <= rows[i].tx;
         i2c_master_model_inst.start_cond();
         i2c_master_model_inst.send_byte(rows[i].abyte, ack);
         wt(8);
         cmp({15'h0, ack}, {15'h0, rows[i].ack}, 16'h0001);
         rd(addr_status, d);
         cmp(d, rows[i].exp, rows[i].mask);
         i2c_master_model_inst.stop_cond();
         wt(8);
         if (rows[i].ack) cmp({15'h0, irq}, 16'h0001, 16'h0001);
         rd(addr_status, d);
         cmp(d, {5'h0, rows[i].ack, 10'h0}, rows[i].ack ? 16'h4440 : 16'h4040);
         rd(addr_status, d);
         cmp(d, 16'h0000, 16'h0400);
         wr(addr_irq_clr, 16'h0007);
         wt(1);
         cmp({15'h0, irq}, 16'h0000, 16'h0001);
         $display("row %0d done", i);
      end
      // rx data, then a repeated start read twice back to back
      i2c_master_model_inst.start_cond();
      i2c_master_model_inst.send_byte(8'h40, ack);
      i2c_master_model_inst.send_byte(8'hA5, ack);
      i2c_master_model_inst.send_byte(8'h5A, ack);
      // third byte into a full fifo; overflow stands one cycle, so poll every cycle
      ovf_seen = 1'b0;
      wt(1);
      fork
         i2c_master_model_inst.send_byte(8'h3C, ack);
         repeat (80) begin
            rd(addr_status, d);
            ovf_seen = ovf_seen | d[st_ovf];
         end
      join
      cmp({15'h0, ovf_seen}, 16'h0001, 16'h0001);
      wt(8);
      rd(addr_status, d);
      cmp(d, 16'h0008, 16'h0018);
      rd(addr_rx_pop, d);
      cmp(d, 16'h00A5, 16'h00FF);
      rd(addr_rx_pop, d);
      cmp(d, 16'h005A, 16'h00FF);
      wt(2);
      rd(addr_status, d);
      cmp(d, 16'h0000, 16'h0008);
      i2c_master_model_inst.start_cond();
      i2c_master_model_inst.send_byte(8'h40, ack);
      wt(8);
      rd(addr_status, d);
      cmp(d, 16'h2000, 16'h2000);
      rd(addr_status, d);
      cmp(d, 16'h0000, 16'h2000);
      i2c_master_model_inst.stop_cond();
      $display("repeated start test done");
      // general calls with the interrupt masked
      wr(addr_irq_en, 16'h0000);
      wr(addr_control, 16'h0001);
      i2c_master_model_inst.start_cond();
      i2c_master_model_inst.send_byte(8'h00, ack);
      cmp({15'h0, ack}, 16'h0001, 16'h0001);
      i2c_master_model_inst.send_byte(8'h04, ack);
      wt(8);
      rd(addr_status, d);
      cmp(d, 16'h4280, 16'h4380);
      i2c_master_model_inst.stop_cond();
      wt(8);
      cmp({15'h0, irq}, 16'h0000, 16'h0001);
      i2c_master_model_inst.start_cond();
      i2c_master_model_inst.send_byte(8'h00, ack);
      i2c_master_model_inst.send_byte(8'h06, ack);
      wt(8);
      rd(addr_status, d);
      cmp(d, 16'h0180, 16'h0380);
      rd(addr_control, d);
      cmp(d, 16'h0000, 16'hFFFF);
      i2c_master_model_inst.stop_cond();
      wt(8);
      wr(addr_control, 16'h0020);
      rd(addr_status, d);
      cmp(d, 16'h0000, 16'h0380);
      // hardware general call: slots are back at zero after the reset command
      wr(addr_alt, 16'h0015);
      wr(addr_control, 16'h0003);
      i2c_master_model_inst.start_cond();
      i2c_master_model_inst.send_byte(8'h00, ack);
      i2c_master_model_inst.send_byte(8'h15, ack);
      wt(8);
      rd(addr_status, d);
      cmp(d, 16'h0388, 16'h0388);
      rd(addr_rx_pop, d);
      cmp(d, 16'h0015, 16'h00FF);
      i2c_master_model_inst.stop_cond();
      $display("general call test done");
      // reset in mid-run while flags stand
      reset <= 1'b1;
      wt(3);
      reset <= 1'b0;
      rd(addr_status, d);
      cmp(d, 16'h0000, 16'hFFFF);
      $display("mid-run reset test done");
      complete_run();
   end
endmodule
`default_nettype wire
